// ### common/dcs_regs.vh
// Purpose: Constants for the disk controller status word
// Assumes: Included by rtl/dcs_status.v
// Notes: Register offsets are the two register-select bits
`ifndef DCS_REGS_VH
`define DCS_REGS_VH
`define DCS_ADDR_STATUS 2'h0
`define DCS_ADDR_COMMAND 2'h0
`define DCS_ADDR_IRQ_MASK 2'h1
`define DCS_ADDR_IRQ_STATUS 2'h2
`define DCS_BIT_NOT_READY 7
`define DCS_BIT_PROTECT 6
`define DCS_BIT_HEAD_LOADED 5
`define DCS_BIT_RECORD_TYPE 5
`define DCS_BIT_SEEK_ERROR 4
`define DCS_BIT_NOT_FOUND 4
`define DCS_BIT_CRC 3
`define DCS_BIT_TRACK_ZERO 2
`define DCS_BIT_LOST_DATA 2
`define DCS_BIT_INDEX 1
`define DCS_BIT_DATA_REQUEST 1
`define DCS_BIT_BUSY 0
`define DCS_CLASS_POS 3'h0
`define DCS_CLASS_READ_ADDR 3'h1
`define DCS_CLASS_READ_SECTOR 3'h2
`define DCS_CLASS_READ_TRACK 3'h3
`define DCS_CLASS_WRITE_SECTOR 3'h4
`define DCS_CLASS_WRITE_TRACK 3'h5
`define DCS_IRQ_DONE 0
`define DCS_IRQ_REFUSED 1
`define DCS_IRQ_MASK_RESET 2'h0
`endif

// ### rtl/dcs_status.v
// Purpose: Status word, command class tracking and interrupt request of a disk controller
// Assumes: Engine inputs come from logic on clk; drive pins are asynchronous
// Notes: Reading the status word also clears the interrupt request
//
// How it works
// - Bit 7 is not ready or reset
// - Positioning: bit 6 inverted write protect
// - Positioning: bit 5 head load and timing
// - Positioning: bit 4 seek error, cleared updating
// - Positioning: bit 3 ID CRC error
// - Positioning: bit 2 inverted track zero
// - Positioning: bit 1 inverted index pulse
// - Bit 0 busy while command executes
// - Refuse data commands when drive not ready
// - Data: bit 6 protect on writes only
// - Data: bit 5 record type, zero on writes
// - Data: bit 4 record not found
// - Data: bit 3 ID or data CRC
// - Data: bit 2 lost data
// - Data: bit 1 mirrors data request
// - Accepted command sets busy, drops interrupt; refused one raises it
// - Interrupt clears on status read, accepted command
//
// The plain strobed port and the address map were left to the implementer.
`include "dcs_regs.vh"
`timescale 1ns/1ps
`default_nettype none
module dcs_status (
    // Clock and reset
    input wire clk,
    input wire reset_n,
    // Register port
    input wire [1:0] addr,
    input wire [7:0] wdata,
    input wire wr_stb,
    input wire rd_stb,
    output reg [7:0] rdata,
    // Drive pins; ready and head load timing active high, the rest active low
    input wire ready_in,
    input wire write_protect_in_n,
    input wire track_zero_in_n,
    input wire index_pulse_in_n,
    input wire head_load_timing_in,
    input wire master_reset_n,
    // Command engine
    input wire [2:0] cmd_class,
    input wire head_load_out,
    input wire engine_done,
    input wire err_seek,
    input wire err_crc,
    input wire err_not_found,
    input wire err_lost_data,
    input wire record_deleted,
    input wire data_request,
    output reg cmd_start,
    output reg busy,
    // Interrupts
    output reg interrupt_request,
    output reg irq
);
    reg [4:0] sync1_reg;
    reg [4:0] sync2_reg;
    reg [2:0] class_reg;
    reg seek_err_reg, crc_reg, rnf_reg, lost_reg, deleted_reg, protect_reg;
    reg [1:0] irq_status_reg;
    reg [1:0] irq_mask_reg;
    reg [7:0] status_next;
    reg [1:0] irq_set;
    wire rdy_s = sync2_reg[0];
    wire wp_n_s = sync2_reg[1];
    wire tr0_n_s = sync2_reg[2];
    wire ip_n_s = sync2_reg[3];
    wire mr_n_s = sync2_reg[4];
    wire cmd_wr = wr_stb && addr == `DCS_ADDR_COMMAND;
    wire is_write = class_reg == `DCS_CLASS_WRITE_SECTOR || class_reg == `DCS_CLASS_WRITE_TRACK;
    wire data_cmd = wdata[7];
    // Data command classes need the drive ready; positioning commands never look at it
    wire refuse = cmd_wr && data_cmd && !rdy_s;
    wire status_rd = rd_stb && addr == `DCS_ADDR_STATUS;

    // Two stages keep metastability out of the status word; head_load_timing_in bypasses them
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_reg <= 5'h1e;
            sync2_reg <= 5'h1e;
        end else begin
            sync1_reg <= {master_reset_n, index_pulse_in_n, track_zero_in_n, write_protect_in_n, ready_in};
            sync2_reg <= sync1_reg;
        end
    end

    always @* begin
        status_next = 8'h00;
        status_next[`DCS_BIT_NOT_READY] = !rdy_s || !mr_n_s;
        status_next[`DCS_BIT_BUSY] = busy;
        if (class_reg == `DCS_CLASS_POS) begin
            status_next[`DCS_BIT_PROTECT] = !wp_n_s;
            status_next[`DCS_BIT_HEAD_LOADED] = head_load_out && head_load_timing_in;
            status_next[`DCS_BIT_SEEK_ERROR] = seek_err_reg;
            status_next[`DCS_BIT_CRC] = crc_reg;
            status_next[`DCS_BIT_TRACK_ZERO] = !tr0_n_s;
            status_next[`DCS_BIT_INDEX] = !ip_n_s;
        end else begin
            status_next[`DCS_BIT_PROTECT] = is_write && protect_reg;
            status_next[`DCS_BIT_RECORD_TYPE] = class_reg == `DCS_CLASS_READ_SECTOR && deleted_reg;
            if (class_reg != `DCS_CLASS_READ_TRACK && class_reg != `DCS_CLASS_WRITE_TRACK) begin
                status_next[`DCS_BIT_NOT_FOUND] = rnf_reg;
                status_next[`DCS_BIT_CRC] = crc_reg;
            end
            status_next[`DCS_BIT_LOST_DATA] = lost_reg;
            status_next[`DCS_BIT_DATA_REQUEST] = data_request;
        end
    end

    always @* begin
        irq_set = 2'h0;
        irq_set[`DCS_IRQ_DONE] = busy && engine_done;
        irq_set[`DCS_IRQ_REFUSED] = refuse;
    end

    // Error flags live for one command; a new command clears them
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            class_reg <= `DCS_CLASS_POS;
            seek_err_reg <= 1'b0;
            crc_reg <= 1'b0;
            rnf_reg <= 1'b0;
            lost_reg <= 1'b0;
            deleted_reg <= 1'b0;
            protect_reg <= 1'b0;
            busy <= 1'b0;
            cmd_start <= 1'b0;
            interrupt_request <= 1'b0;
        end else begin
            cmd_start <= cmd_wr && !refuse;
            if (cmd_wr) begin
                class_reg <= data_cmd ? wdata[2:0] : `DCS_CLASS_POS;
                seek_err_reg <= 1'b0;
                crc_reg <= 1'b0;
                rnf_reg <= 1'b0;
                lost_reg <= 1'b0;
                deleted_reg <= 1'b0;
                protect_reg <= 1'b0;
                busy <= !refuse;
                interrupt_request <= refuse;
            end else begin
                if (busy) begin
                    if (err_seek) seek_err_reg <= 1'b1;
                    if (err_crc) crc_reg <= 1'b1;
                    if (err_not_found) rnf_reg <= 1'b1;
                    if (err_lost_data) lost_reg <= 1'b1;
                    if (record_deleted) deleted_reg <= 1'b1;
                    if (is_write && !wp_n_s) protect_reg <= 1'b1;
                end
                if (busy && engine_done) begin
                    busy <= 1'b0;
                    interrupt_request <= 1'b1;
                end else if (status_rd) begin
                    interrupt_request <= 1'b0;
                end
            end
        end
    end

    // Sticky events; set beats a write-one clear in the same cycle
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_status_reg <= 2'h0;
            irq_mask_reg <= `DCS_IRQ_MASK_RESET;
            irq <= 1'b0;
            rdata <= 8'h00;
        end else begin
            if (wr_stb && addr == `DCS_ADDR_IRQ_MASK) irq_mask_reg <= wdata[1:0];
            if (wr_stb && addr == `DCS_ADDR_IRQ_STATUS)
                irq_status_reg <= (irq_status_reg & ~wdata[1:0]) | irq_set;
            else
                irq_status_reg <= irq_status_reg | irq_set;
            irq <= |(irq_status_reg & irq_mask_reg);
            if (rd_stb) begin
                case (addr)
                    `DCS_ADDR_STATUS: rdata <= status_next;
                    `DCS_ADDR_IRQ_MASK: rdata <= {6'h00, irq_mask_reg};
                    `DCS_ADDR_IRQ_STATUS: rdata <= {6'h00, irq_status_reg};
                    default: rdata <= 8'h00;
                endcase
            end else begin
                rdata <= 8'h00;
            end
        end
    end
endmodule // dcs_status
`default_nettype wire

// ### verif/dcs_checker.sv
// Purpose: Port checks for dcs_status
// Assumes: Drive pins settle within 3 samples
// Notes: Bound from tb_top
`timescale 1ns/1ps
`default_nettype none
module dcs_checker (
    input wire logic clk, reset_n, wr_stb, rd_stb, ready_in,
    input wire logic engine_done, busy, cmd_start, interrupt_request,
    input wire logic [1:0] addr,
    input wire logic [7:0] wdata, rdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire logic cw = wr_stb && addr == 2'h0;
    wire logic sr = rd_stb && addr == 2'h0;
    a_cmd_sets_busy: assert property (cw && !wdata[7] && !busy
        |=> busy && cmd_start && !interrupt_request) else $error("no start");
    a_refuse_data: assert property ((!ready_in)[*3] ##0 (cw && wdata[7] && !busy)
        |=> !busy && !cmd_start && interrupt_request) else $error("not refused");
    a_done_idles: assert property (busy && engine_done && !cw
        |=> !busy && interrupt_request) else $error("done missed");
    a_read_clears: assert property (interrupt_request && sr && !engine_done
        |=> !interrupt_request) else $error("irq kept");
    a_irq_holds: assert property (interrupt_request && !cw && !sr
        |=> interrupt_request) else $error("irq lost");
    a_busy_bit: assert property (sr |=> rdata[0] == $past(busy))
        else $error("busy bit");
    a_not_ready: assert property ((!ready_in)[*3] ##0 sr |=> rdata[7])
        else $error("ready bit");
    a_rdata_idle: assert property (!rd_stb |=> rdata == 8'h00)
        else $error("rdata idle");
endmodule // dcs_checker
`default_nettype wire

// ### verif/dcs_host.sv
// Purpose: Host side of the register port
// Assumes: Strobes change just after rising edges
// Notes: Read data taken at the edge that ends the cycle they stand in
`timescale 1ns/1ps
`default_nettype none
module dcs_host (
    input wire logic clk,
    input wire logic [7:0] rdata,
    output logic [1:0] addr,
    output logic [7:0] wdata,
    output logic wr_stb, rd_stb
);
    initial {addr, wdata, wr_stb, rd_stb} = 12'h0;
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [1:0] a, output logic [7:0] q);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        @(posedge clk);
        q = rdata;
    endtask
endmodule // dcs_host
`default_nettype wire

// ### verif/tb_top.sv
// Purpose: Self-checking bench for dcs_status
// Assumes: 10 MHz clock, reset low 5 cycles
// Notes: Waits of 3 cycles cover the pin synchronisers
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk = 0, reset_n = 0, ready_in = 1, write_protect_in_n = 1, track_zero_in_n = 1;
    logic index_pulse_in_n = 1, head_load_timing_in = 0, master_reset_n = 1, head_load_out = 0;
    logic engine_done = 0, err_seek = 0, err_crc = 0, err_not_found = 0, err_lost_data = 0;
    logic record_deleted = 0, data_request = 0, wr_stb, rd_stb, cmd_start, busy, interrupt_request, irq;
    logic [1:0] addr;
    logic [7:0] wdata, rdata, q;
    int err_count = 0, num_checks = 0;
    dcs_status dut (.clk, .reset_n, .addr, .wdata, .wr_stb, .rd_stb, .rdata, .ready_in, .write_protect_in_n,
        .track_zero_in_n, .index_pulse_in_n, .head_load_timing_in, .master_reset_n, .cmd_class(3'h0),
        .head_load_out, .engine_done, .err_seek, .err_crc, .err_not_found, .err_lost_data, .record_deleted,
        .data_request, .cmd_start, .busy, .interrupt_request, .irq);
    dcs_host host (.clk, .rdata, .addr, .wdata, .wr_stb, .rd_stb);
    initial forever #50 clk = ~clk;
    task automatic chk(input string n, input logic [8:0] s, e);
        num_checks++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s exp %h seen %h", n, e, s);
        end
    endtask
    task automatic print_verdict;
        if (err_count == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic t_position;
        {write_protect_in_n, track_zero_in_n, index_pulse_in_n} <= 3'h0;
        {head_load_out, head_load_timing_in} <= 2'h3;
        host.wr(2'h0, 8'h10);
        host.rd(2'h0, q);
        chk("pos", q, 8'h67);
        {err_seek, err_crc} <= 2'h3;
        @(posedge clk);
        engine_done <= 1;
        @(posedge clk);
        {err_seek, err_crc, engine_done} <= 3'h0;
        @(posedge clk);
        chk("irq", {7'h0, interrupt_request}, 8'h01);
        host.rd(2'h0, q);
        chk("pos err", q, 8'h7e);
    endtask
    task automatic t_data;
        logic [7:0] c, e[5] = '{8'h1c, 8'h3c, 8'h04, 8'h5c, 8'h44};
        for (int i = 0; i < 5; i++) begin
            c = 8'h81 + i;
            host.wr(2'h0, c);
            data_request <= 1;
            host.rd(2'h0, q);
            chk("busy", q, c[2] ? 8'h43 : 8'h03);
            {err_crc, err_not_found, err_lost_data, record_deleted} <= 4'hf;
            @(posedge clk);
            {engine_done, data_request} <= 2'h2;
            @(posedge clk);
            {err_crc, err_not_found, err_lost_data, record_deleted, engine_done} <= 5'h0;
            host.rd(2'h0, q);
            chk("data", q, e[i]);
        end
    endtask
    task automatic t_refuse;
        host.wr(2'h2, 8'h03);
        host.wr(2'h1, 8'h02);
        ready_in <= 0;
        repeat (3) @(posedge clk);
        host.wr(2'h0, 8'h82);
        @(posedge clk);
        chk("refuse", {6'h0, busy, interrupt_request}, 8'h01);
        host.rd(2'h2, q);
        chk("irq st", {q, irq}, 9'h005);
        host.wr(2'h2, 8'h02);
        host.rd(2'h0, q);
        chk("nrdy", {q & 8'h81, irq}, 9'h100);
        // ready_in is held high for this reset pulse
        {ready_in, master_reset_n} <= 2'h2;
        repeat (3) @(posedge clk);
        host.rd(2'h0, q);
        chk("mr", q & 8'h80, 8'h80);
        master_reset_n <= 1;
    endtask
    initial begin
        repeat (5) @(posedge clk);
        reset_n <= 1;
        repeat (3) @(posedge clk);
        t_position;
        t_data;
        t_refuse;
        print_verdict;
    end
    // Whole run is some 93 cycles; about sixteen times that means a hang
    initial begin
        #150000;
        err_count++;
        print_verdict;
    end
endmodule // tb_top
bind dcs_status dcs_checker chk_i (.clk, .reset_n, .wr_stb, .rd_stb, .ready_in, .engine_done, .busy,
    .cmd_start, .interrupt_request, .addr, .wdata, .rdata);
`default_nettype wire
